// [rtl/pcm_capture_top.sv]
// The implementer's own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ns
`include "pcm_map.svh"
module pcm_capture_top import pcm_pkg::*; #(
	parameter int HIST = 9
) (
	// apb slave
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// parallel pixel bus pins
	input  wire logic        pixel_input_clock_p,
	input  wire logic        pixel_input_clock_n,
	input  wire logic [23:0] pixel_data,
	input  wire logic        active_video_flag,
	input  wire logic        hsync_in,
	input  wire logic        vsync_in,
	input  wire logic [2:0]  blanking_control_bits,
	// configuration pins
	input  wire logic        bus_select_reset,
	input  wire logic        bus_width_select,
	input  wire logic        clock_style_select,
	input  wire logic        latch_edge_select,
	input  wire logic        deskew_enable,
	input  wire logic [2:0]  deskew_setting,
	input  wire logic        ref_low_swing,
	// encoded channels
	output logic      [9:0]  red_output_channel,
	output logic      [9:0]  green_output_channel,
	output logic      [9:0]  blue_output_channel,
	output logic             char_valid
);

	// ----------------------------------------
	// constants
	// ----------------------------------------
	localparam int STEP_CYC_RAW = (`PCM_DSK_STEP_NS * `PCM_PCLK_MHZ) / 1000;
	localparam int STEP_CYC     = (STEP_CYC_RAW < 1) ? 1 : STEP_CYC_RAW;
	localparam int CENTER       = `PCM_DSK_CENTER * STEP_CYC;
	localparam int DEPTH        = (HIST > 2 * CENTER) ? HIST : 2 * CENTER + 1;

	// ----------------------------------------
	// functions
	// ----------------------------------------
	// differential clocking is a low-swing feature only
	function automatic logic pcm_diff_mode(input logic low, input pcm_cfg_t c);
		pcm_diff_mode = low && (c.wide ? c.style : !c.style); // [RQ8] [RQ14] [RQ15]
	endfunction

	// history tap that lines data up with the delayed edge
	function automatic int pcm_tap(input pcm_cfg_t c);
		if (c.dk_en)
			pcm_tap = (2 * `PCM_DSK_CENTER - int'(c.dk)) * STEP_CYC; // [RQ21]
		else
			pcm_tap = CENTER; // [RQ21]
	endfunction

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	pcm_sample_t smp_s;
	logic        ck_p_s;
	logic        ck_n_s;
	logic        bus_sel_s;
	pcm_cfg_t    pin_cfg_s;
	logic        low_s;

	pcm_sync #(
		.W ($bits(pcm_sample_t) + 2)
	) u_sync_pix (
		.clk   (pclk),
		.rst_n (presetn),
		.d     ({active_video_flag, vsync_in, hsync_in, blanking_control_bits, pixel_data,
		         pixel_input_clock_p, pixel_input_clock_n}),
		.q     ({smp_s, ck_p_s, ck_n_s})
	);

	pcm_sync #(
		.W ($bits(pcm_cfg_t) + 2)
	) u_sync_cfg (
		.clk   (pclk),
		.rst_n (presetn),
		.d     ({bus_select_reset, ref_low_swing, bus_width_select, clock_style_select,
		         latch_edge_select, deskew_enable, deskew_setting}),
		.q     ({bus_sel_s, low_s, pin_cfg_s})
	);

	// ----------------------------------------
	// mode register and configuration select
	// ----------------------------------------
	logic     [6:0] mode_r;
	pcm_cfg_t       cfg;
	logic           diff_on;
	logic           wr_hit;

	assign wr_hit = psel && penable && pready && pwrite && paddr == `PCM_MODE_OFS;

	// bus-select pin low holds the registers at their defaults
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			mode_r <= `PCM_MODE_RST;
		else if (!bus_sel_s)
			mode_r <= `PCM_MODE_RST; // [RQ22]
		else if (wr_hit)
			mode_r <= pwdata[`PCM_F_DK_HI:`PCM_F_WIDE];
	end

	// registers when the bus is enabled, pins otherwise
	always_comb begin
		if (bus_sel_s) begin
			cfg.wide      = mode_r[`PCM_F_WIDE]; // [RQ17] [RQ22]
			cfg.style     = mode_r[`PCM_F_STYLE];
			cfg.edge_rise = mode_r[`PCM_F_EDGE];
			cfg.dk_en     = mode_r[`PCM_F_DESKEW_ENABLE];
			cfg.dk        = mode_r[`PCM_F_DK_HI:`PCM_F_DK_LO];
		end else begin
			cfg = pin_cfg_s; // [RQ17]
		end
	end

	assign diff_on = pcm_diff_mode(low_s, cfg);

	// ----------------------------------------
	// clock level recovery and edge finding
	// ----------------------------------------
	logic lvl_r;
	logic lvl_d_r;
	logic rise;
	logic fall;

	// differential: level changes only where the inputs cross
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			lvl_r <= 1'b0;
		else if (!diff_on)
			lvl_r <= ck_p_s; // [RQ9] [RQ15] negative input ignored
		else if (ck_p_s != ck_n_s)
			lvl_r <= ck_p_s; // [RQ7]
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			lvl_d_r <= 1'b0;
		else
			lvl_d_r <= lvl_r;
	end

	assign rise = lvl_r && !lvl_d_r;
	assign fall = !lvl_r && lvl_d_r;

	// ----------------------------------------
	// deskew: sample history and delayed edges
	// ----------------------------------------
	pcm_sample_t     hist_r [DEPTH];
	logic [CENTER:1] rise_d_r;
	logic [CENTER:1] fall_d_r;
	pcm_sample_t     tap_smp;
	logic            pri;
	logic            opp;

	// edges wait CENTER cycles so data may be taken early or late
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rise_d_r <= '0;
			fall_d_r <= '0;
		end else begin
			rise_d_r <= {rise_d_r[CENTER-1:1], rise};
			fall_d_r <= {fall_d_r[CENTER-1:1], fall};
		end
	end

	// sample history aligned with the edge pipe
	generate
		for (genvar i = 0; i < DEPTH; i++) begin : g_hist
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn)
					hist_r[i] <= '0;
				else if (i == 0)
					hist_r[i] <= smp_s;
				else
					hist_r[i] <= hist_r[(i == 0) ? 0 : i-1];
			end
		end
	endgenerate

	assign tap_smp = hist_r[pcm_tap(cfg)]; // [RQ20]

	// primary edge from edge select, both modes
	assign pri = cfg.edge_rise ? rise_d_r[CENTER] : fall_d_r[CENTER]; // [RQ12] [RQ13]
	assign opp = cfg.edge_rise ? fall_d_r[CENTER] : rise_d_r[CENTER];

	// ----------------------------------------
	// capture and pixel assembly
	// ----------------------------------------
	pcm_phase_t  ph_r;
	logic [11:0] lo_r;
	pcm_sample_t pix_r;
	logic        pix_stb_r;

	// width alone decides single or dual edge use
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ph_r <= PCM_PH_LOW;
		end else if (cfg.wide) begin
			ph_r <= PCM_PH_LOW; // [RQ16] no second word in 24-bit mode
		end else begin
			case (ph_r)
				PCM_PH_LOW:  if (pri) ph_r <= PCM_PH_HIGH; // [RQ23]
				PCM_PH_HIGH: if (opp) ph_r <= PCM_PH_LOW; // [RQ11]
				default:     ph_r <= PCM_PH_LOW;
			endcase
		end
	end

	// low word kept until its high partner arrives
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			lo_r <= 12'h000;
		else if (!cfg.wide && ph_r == PCM_PH_LOW && pri)
			lo_r <= tap_smp.data[11:0]; // [RQ23]
	end

	// pixel register; syncs follow the data word that completes the pixel
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pix_r     <= '0;
			pix_stb_r <= 1'b0;
		end else begin
			pix_stb_r <= 1'b0;
			if (cfg.wide && pri) begin
				pix_r     <= tap_smp; // [RQ10] [RQ12]
				pix_stb_r <= 1'b1;
			end else if (!cfg.wide && ph_r == PCM_PH_HIGH && opp) begin
				pix_r      <= tap_smp; // [RQ10] [RQ11]
				pix_r.data <= {tap_smp.data[11:0], lo_r}; // [RQ18]
				pix_stb_r  <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// channel mapping and encoders
	// ----------------------------------------
	logic [7:0] ch_d   [3];
	logic [1:0] ch_c   [3];
	logic [9:0] ch_q   [3];

	// colour bytes by channel; controls only matter in blanking
	// controller keeps controls steady during active video [RQ6]
	always_comb begin
		ch_d[2] = pix_r.data[23:16]; // [RQ3]
		ch_d[1] = pix_r.data[15:8];
		ch_d[0] = pix_r.data[7:0];
		ch_c[0] = {pix_r.vs, pix_r.hs}; // [RQ2]
		ch_c[1] = {pix_r.ctl[0], 1'b0}; // [RQ4]
		ch_c[2] = {1'b0, pix_r.ctl[1]}; // [RQ4] [RQ5]
	end

	generate
		for (genvar k = 0; k < 3; k++) begin : g_enc
			pcm_tmds_enc u_enc (
				.clk   (pclk),
				.rst_n (presetn),
				.stb   (pix_stb_r),
				.de    (pix_r.de), // [RQ2]
				.d     (ch_d[k]),
				.c     (ch_c[k]),
				.q     (ch_q[k])
			);
		end
	endgenerate

	assign red_output_channel   = ch_q[2];
	assign green_output_channel = ch_q[1];
	assign blue_output_channel  = ch_q[0];

	// marks the cycle a new character set stands
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			char_valid <= 1'b0;
		else
			char_valid <= pix_stb_r;
	end

	// ----------------------------------------
	// pixel counter for status
	// ----------------------------------------
	logic [15:0] pix_cnt_r;

	// wraps silently; software only needs to see motion
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			pix_cnt_r <= 16'h0000;
		else if (pix_stb_r && pix_r.de)
			pix_cnt_r <= pix_cnt_r + 16'h0001;
	end

	// ----------------------------------------
	// apb answer
	// ----------------------------------------
	logic [31:0] rd_nxt;
	logic        err_nxt;

	// read mux; unmapped offsets answer with an error
	always_comb begin
		rd_nxt  = 32'h0000_0000;
		err_nxt = 1'b0;
		case (paddr)
			`PCM_MODE_OFS: rd_nxt[6:0] = mode_r;
			`PCM_STAT_OFS: begin
				rd_nxt[6:0]                     = {cfg.dk, cfg.dk_en, cfg.edge_rise, cfg.style, cfg.wide};
				rd_nxt[`PCM_S_DIFF]             = diff_on;
				rd_nxt[`PCM_S_BUSSEL]           = bus_sel_s;
				rd_nxt[`PCM_S_DE]               = pix_r.de;
				rd_nxt[`PCM_S_CNT_LO +: 16]     = pix_cnt_r;
				err_nxt                         = pwrite;
			end
			default: err_nxt = 1'b1;
		endcase
	end

	// one wait-free access phase: ready rises the cycle after setup
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel && !penable && !pready;
			prdata  <= (psel && !penable && !pwrite) ? rd_nxt : 32'h0000_0000;
			pslverr <= psel && !penable && err_nxt;
		end
	end

endmodule

// [rtl/pcm_map.svh]
//
// Contract
// RQ1 - encoder picks the character that minimises transitions and tracks running dc balance
// RQ2 - active video sends colour; blanking sends both syncs and control bits
// RQ3 - red bits 23..16 on channel 2, green 15..8 on 1, blue 7..0 on 0
// RQ4 - blanking sends control bits 3,2 on channel 2 and bit 1 on channel 1
// RQ5 - control bit 3 always goes out as zero
// RQ6 - controller holds control and sync inputs steady while active video is high
// RQ7 - differential mode takes clock timing from the crossing of both clock inputs
// RQ8 - differential clocking only offered in low-swing reference mode
// RQ9 - single-ended clock drives the positive input, negative input grounded
// RQ10 - width select low gives 12-bit dual edge, high gives 24-bit single edge
// RQ11 - 12-bit mode latches a word on both clock edges, two words per pixel
// RQ12 - 24-bit mode latches on rising edge if edge select is one, else falling
// RQ13 - in 12-bit mode edge select picks the primary latching edge
// RQ14 - low swing: 12-bit style 0 differential; 24-bit style 1 differential
// RQ15 - high swing ignores clock style select and latches single-ended
// RQ16 - no 12-bit single-edge and no 24-bit dual-edge mode exist
// RQ17 - width, style, edge from register when bus enabled, else from pins
// RQ18 - 12-bit low word {g3..0,b7..0}, high word {r7..0,g7..4}
// RQ19 - system should avoid single-ended clocking in low-swing mode
// RQ20 - deskew enable and three-bit setting move the data capture instant
// RQ21 - offset is setting minus four steps when enabled, default when disabled
// RQ22 - bus-select pin high uses and enables registers, low uses pins
// RQ23 - 12-bit low word on primary edge, high word on following opposite edge
`ifndef PCM_MAP_SVH
`define PCM_MAP_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define PCM_MODE_OFS     12'h000
`define PCM_STAT_OFS     12'h004

// ----------------------------------------
// mode register fields and reset value
// ----------------------------------------
`define PCM_F_WIDE       0
`define PCM_F_STYLE      1
`define PCM_F_EDGE       2
`define PCM_F_DESKEW_ENABLE       3
`define PCM_F_DK_LO      4
`define PCM_F_DK_HI      6
`define PCM_MODE_RST     7'h00

// ----------------------------------------
// status register fields
// ----------------------------------------
`define PCM_S_DIFF       7
`define PCM_S_BUSSEL     8
`define PCM_S_DE         9
`define PCM_S_CNT_LO     16

// ----------------------------------------
// timing
// ----------------------------------------
`define PCM_PCLK_MHZ     10
`define PCM_DSK_STEP_NS  100
`define PCM_DSK_CENTER   4

// ----------------------------------------
// control characters
// ----------------------------------------
`define PCM_CTL_00       10'h354
`define PCM_CTL_01       10'h0AB
`define PCM_CTL_10       10'h154
`define PCM_CTL_11       10'h2AB

`endif

// [rtl/pcm_pkg.sv]
package pcm_pkg;

	// one sampled snapshot of the parallel pixel bus
	typedef struct packed {
		logic        de;
		logic        vs;
		logic        hs;
		logic [2:0]  ctl;
		logic [23:0] data;
	} pcm_sample_t;

	// effective interface configuration
	typedef struct packed {
		logic       wide;
		logic       style;
		logic       edge_rise;
		logic       dk_en;
		logic [2:0] dk;
	} pcm_cfg_t;

	// word phase of 12-bit capture
	typedef enum logic {PCM_PH_LOW, PCM_PH_HIGH} pcm_phase_t;

endpackage

// [rtl/pcm_sync.sv]
`timescale 1ns/1ns
// two-flop synchroniser for pins from outside pclk
module pcm_sync #(
	parameter int W = 1
) (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         rst_n,
	// pin side and synchronised side
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	logic [W-1:0] meta_r;

	// first stage feeds only the second
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_r <= '0;
			q      <= '0;
		end else begin
			meta_r <= d;
			q      <= meta_r;
		end
	end

endmodule

// [rtl/pcm_tmds_enc.sv]
`timescale 1ns/1ns
// one channel: 8b to 10b with running disparity
module pcm_tmds_enc (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst_n,
	// symbol in
	input  wire logic       stb,
	input  wire logic       de,
	input  wire logic [7:0] d,
	input  wire logic [1:0] c,
	// character out
	output logic      [9:0] q
);

	logic        use_xnor;
	logic [8:0]  qm;
	logic [3:0]  n1d;
	logic [3:0]  n1q;
	logic signed [4:0] diff;
	logic signed [4:0] cnt_r;
	logic signed [4:0] cnt_nxt;
	logic [9:0]  q_nxt;

	// stage one: transition minimising
	always_comb begin
		n1d = 4'h0;
		for (int i = 0; i < 8; i++) n1d = n1d + 4'(d[i]);
		use_xnor = (n1d > 4'h4) || (n1d == 4'h4 && !d[0]);
		qm[0] = d[0];
		for (int i = 1; i < 8; i++) qm[i] = use_xnor ? ~(qm[i-1] ^ d[i]) : (qm[i-1] ^ d[i]);
		qm[8] = !use_xnor;
		n1q = 4'h0;
		for (int i = 0; i < 8; i++) n1q = n1q + 4'(qm[i]);
		diff = 5'(signed'({1'b0, n1q, 1'b0})) - 5'sh08; // ones minus zeros
	end

	// stage two: dc balance against the running tally [RQ1]
	always_comb begin
		if (!de) begin
			cnt_nxt = 5'sh00;
			case (c)
				2'h0:    q_nxt = `PCM_CTL_00;
				2'h1:    q_nxt = `PCM_CTL_01;
				2'h2:    q_nxt = `PCM_CTL_10;
				default: q_nxt = `PCM_CTL_11;
			endcase
		end else if (cnt_r == 5'sh00 || diff == 5'sh00) begin
			q_nxt   = {~qm[8], qm[8], qm[8] ? qm[7:0] : ~qm[7:0]};
			cnt_nxt = qm[8] ? cnt_r + diff : cnt_r - diff;
		end else if ((cnt_r > 0 && diff > 0) || (cnt_r < 0 && diff < 0)) begin
			q_nxt   = {1'b1, qm[8], ~qm[7:0]};
			cnt_nxt = cnt_r + (qm[8] ? 5'sh02 : 5'sh00) - diff;
		end else begin
			q_nxt   = {1'b0, qm[8], qm[7:0]};
			cnt_nxt = cnt_r - (qm[8] ? 5'sh00 : 5'sh02) + diff;
		end
	end

	// character and tally advance once per pixel
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q     <= `PCM_CTL_00;
			cnt_r <= 5'sh00;
		end else if (stb) begin
			q     <= q_nxt;
			cnt_r <= cnt_nxt;
		end
	end

endmodule

// [tb/pcm_capture_monitor.sv]
`timescale 1ns/1ns
module pcm_capture_monitor (
	// apb side
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// encoded channels
	input wire logic [9:0]  red_output_channel,
	input wire logic [9:0]  green_output_channel,
	input wire logic [9:0]  blue_output_channel,
	input wire logic        char_valid
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// ----------------------------------------
	// register bus
	// ----------------------------------------
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_access;
		psel && penable;
	endsequence
	// no wait states: answer in the first access cycle
	property p_no_wait;
		s_setup ##1 s_access |-> pready;
	endproperty
	a_no_wait: assert property (p_no_wait) else $error("pready late");
	property p_ready_in_access;
		pready |-> psel && penable;
	endproperty
	a_ready_in_access: assert property (p_ready_in_access) else $error("pready outside access");
	property p_ready_pulse;
		pready |=> !pready;
	endproperty
	a_ready_pulse: assert property (p_ready_pulse) else $error("pready too long");
	// read data is driven only with the answer, so a stale word never leaks
	property p_quiet_data;
		!pready |-> prdata == 32'h0;
	endproperty
	a_quiet_data: assert property (p_quiet_data) else $error("prdata not idle");
	property p_bad_addr;
		pready && paddr != 12'h000 && paddr != 12'h004 |-> pslverr;
	endproperty
	a_bad_addr: assert property (p_bad_addr) else $error("unmapped access accepted");
	property p_status_wr;
		pready && pwrite && paddr == 12'h004 |-> pslverr;
	endproperty
	a_status_wr: assert property (p_status_wr) else $error("status write accepted");
	property p_mode_ok;
		pready && paddr == 12'h000 |-> !pslverr && prdata[31:7] == 25'h0;
	endproperty
	a_mode_ok: assert property (p_mode_ok) else $error("mode access wrong");

	// ----------------------------------------
	// encoded channels
	// ----------------------------------------
	property p_hold_chars;
		!char_valid |-> $stable({red_output_channel, green_output_channel, blue_output_channel});
	endproperty
	a_hold_chars: assert property (p_hold_chars) else $error("characters moved");
	property p_valid_pulse;
		char_valid |=> !char_valid;
	endproperty
	a_valid_pulse: assert property (p_valid_pulse) else $error("char_valid too long");
	// control bit 3 rides red c1; a set c1 would show as 154 or 2AB
	property p_ctl3_silent;
		char_valid |-> red_output_channel != 10'h154 && red_output_channel != 10'h2AB;
	endproperty
	a_ctl3_silent: assert property (p_ctl3_silent) else $error("reserved bit sent");
	property p_green_c0;
		char_valid |-> green_output_channel != 10'h0AB && green_output_channel != 10'h2AB;
	endproperty
	a_green_c0: assert property (p_green_c0) else $error("green c0 set");
endmodule

bind pcm_capture_top pcm_capture_monitor u_pcm_capture_monitor (
	.pclk                 (pclk),
	.presetn              (presetn),
	.psel                 (psel),
	.penable              (penable),
	.pwrite               (pwrite),
	.paddr                (paddr),
	.prdata               (prdata),
	.pready               (pready),
	.pslverr              (pslverr),
	.red_output_channel   (red_output_channel),
	.green_output_channel (green_output_channel),
	.blue_output_channel  (blue_output_channel),
	.char_valid           (char_valid)
);

// [tb/pcm_gfx_model.sv]
`timescale 1ns/1ns
// graphics controller: pixel clock moves only inside frames
module pcm_gfx_model import pcm_pkg::*; (
	// clock style in use
	input  wire logic  diff_mode,
	// pins toward the block
	output logic       clk_p,
	output logic       clk_n,
	output pcm_sample_t bus
);
	initial begin
		clk_p = 1'b0;
		bus   = '0;
	end
	// negative pin grounded single ended, mirrored when differential
	assign clk_n = diff_mode ? ~clk_p : 1'b0;
	// half period: word settles four pclk ahead, then the edge
	task automatic word(input pcm_sample_t s);
		bus = s;
		#400;
		clk_p = ~clk_p;
		#400;
	endtask
	// park the clock so the first toggle of a frame is the primary edge
	task automatic park(input logic lvl);
		clk_p = lvl;
	endtask
	// released bus shows the inverse so stale values never match
	task automatic release_bus();
		bus = ~bus;
	endtask
endmodule

// [tb/test_pixel_capture_channel_mapper.sv]
`timescale 1ns/1ns
module test_pixel_capture_channel_mapper import pcm_pkg::*;;
	logic        pclk, presetn, psel, penable, pwrite, char_valid, pready, pslverr;
	logic        clk_p, clk_n, diff_mode, bus_select_reset, ref_low_swing;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [9:0]  ch_r, ch_g, ch_b;
	pcm_cfg_t    pins;
	pcm_sample_t bus;
	logic [29:0] seen[$];
	int          fail_count, samples_checked, cycles;
	localparam logic [9:0] CODES [4] = '{10'h354, 10'h0AB, 10'h154, 10'h2AB};

	pcm_capture_top u_pcm_capture_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.pixel_input_clock_p(clk_p), .pixel_input_clock_n(clk_n), .pixel_data(bus.data),
		.active_video_flag(bus.de), .hsync_in(bus.hs), .vsync_in(bus.vs), .blanking_control_bits(bus.ctl),
		.bus_select_reset(bus_select_reset), .bus_width_select(pins.wide), .clock_style_select(pins.style),
		.latch_edge_select(pins.edge_rise), .deskew_enable(pins.dk_en), .deskew_setting(pins.dk),
		.ref_low_swing(ref_low_swing), .red_output_channel(ch_r), .green_output_channel(ch_g),
		.blue_output_channel(ch_b), .char_valid(char_valid));
	pcm_gfx_model u_pcm_gfx_model (.diff_mode(diff_mode), .clk_p(clk_p), .clk_n(clk_n), .bus(bus));

	// ----------------------------------------
	// clock, capture, timeout
	// ----------------------------------------
	always #50 pclk = ~pclk;
	always @(posedge pclk) begin
		if (char_valid === 1'b1)
			seen.push_back({ch_r, ch_g, ch_b});
	end
	// whole run is near 1600 cycles
	always @(posedge pclk) begin
		cycles <= cycles + 1;
		if (cycles == 6000) begin
			fail_count++;
			complete_run();
		end
	end

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic complete_run();
		$display("checked %0d mismatched %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD t=%0t seen=%h want=%h", $time, got, exp);
		end
	endtask
	// one transfer; the answer is awaited, the timeout cuts a hang
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic err);
		@(posedge pclk);
		psel   <= 1'b1;
		pwrite <= wr;
		paddr  <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask
	function automatic logic [6:0] cfg_bits(input pcm_cfg_t c);
		return {c.dk, c.dk_en, c.edge_rise, c.style, c.wide};
	endfunction
	// undo the transition coding to recover the byte
	function automatic logic [7:0] dec(input logic [9:0] q);
		logic [7:0] x;
		logic [7:0] d;
		x = q[9] ? ~q[7:0] : q[7:0];
		d[0] = x[0];
		for (int i = 1; i < 8; i++)
			d[i] = q[8] ? x[i] ^ x[i-1] : ~(x[i] ^ x[i-1]);
		return d;
	endfunction
	function automatic logic [29:0] view(input logic [29:0] t, input logic de);
		if (de)
			return {6'h00, dec(t[29:20]), dec(t[19:10]), dec(t[9:0])};
		return t;
	endfunction
	function automatic logic [29:0] want(input pcm_sample_t s);
		if (s.de)
			return {6'h00, s.data};
		return {CODES[{1'b0, s.ctl[1]}], CODES[{s.ctl[0], 1'b0}], CODES[{s.vs, s.hs}]};
	endfunction

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_regs();
		logic [31:0] rd;
		logic        err;
		@(posedge pclk);
		bus_select_reset <= 1'b1;
		repeat (4) @(posedge pclk);
		apb(1'b0, 12'h000, 32'h0, rd, err);
		check(rd, 32'h0);
		apb(1'b1, 12'h000, 32'hFFFF_FFD5, rd, err);
		check(err, 1'b0);
		apb(1'b0, 12'h000, 32'h0, rd, err);
		check(rd, 32'h55);
		apb(1'b0, 12'h004, 32'h0, rd, err);
		check(rd[8:0], 9'h155);
		apb(1'b1, 12'h004, 32'h7F, rd, err);
		check(err, 1'b1);
		apb(1'b0, 12'h008, 32'h0, rd, err);
		check(err, 1'b1);
		bus_select_reset <= 1'b0;
		repeat (4) @(posedge pclk);
		apb(1'b1, 12'h000, 32'h7F, rd, err);
		apb(1'b0, 12'h000, 32'h0, rd, err);
		check(rd, 32'h0);
		apb(1'b0, 12'h004, 32'h0, rd, err);
		check(rd[8:0], {2'b00, cfg_bits(pins)});
		$display("register test done");
	endtask
	task automatic t_style();
		logic [31:0] rd;
		logic        err;
		for (int i = 0; i < 8; i++) begin
			@(posedge pclk);
			ref_low_swing <= i[2];
			pins.wide     <= i[1];
			pins.style    <= i[0];
			repeat (4) @(posedge pclk);
			apb(1'b0, 12'h004, 32'h0, rd, err);
			check(rd[7], i[2] & (i[1] == i[0]));
		end
		$display("clock style test done");
	endtask
	// alternating active and blanking pixels, back to back
	task automatic t_frame(input logic r, input pcm_cfg_t c, input logic twelve, input logic dm);
		pcm_sample_t px[$];
		pcm_sample_t s;
		for (int i = 0; i < 8; i++) begin
			s = '0;
			s.de = 1'b1;
			s.data = {8'h10 + 8'(i), 8'h80 - 8'(i), 8'hF0 ^ 8'(i)};
			px.push_back(s);
			s.de = 1'b0;
			s.vs = i[1];
			s.hs = i[0];
			s.ctl = {1'b1, i[2], i[0] ^ i[1]};
			px.push_back(s);
		end
		@(posedge pclk);
		ref_low_swing <= r;
		pins          <= c;
		diff_mode     <= dm;
		repeat (5) @(posedge pclk);
		seen.delete();
		@(negedge pclk);
		if (twelve)
			u_pcm_gfx_model.park(!c.edge_rise);
		foreach (px[i]) begin
			s = px[i];
			if (twelve) begin
				s.data = {~px[i].data[23:12], px[i].data[11:0]};
				u_pcm_gfx_model.word(s);
				s.data = {~px[i].data[11:0], px[i].data[23:12]};
				u_pcm_gfx_model.word(s);
			end else begin
				u_pcm_gfx_model.word(s);
				u_pcm_gfx_model.word(s);
			end
		end
		u_pcm_gfx_model.release_bus();
		repeat (30) @(posedge pclk);
		check(32'(seen.size()), 32'(px.size()));
		foreach (px[i])
			check(view(seen[i], px[i].de), want(px[i]));
		$display("frame test done");
	endtask
	task automatic t_regframe();
		logic [31:0] rd;
		logic        err;
		@(posedge pclk);
		bus_select_reset <= 1'b1;
		repeat (4) @(posedge pclk);
		apb(1'b1, 12'h000, 32'h05, rd, err);
		t_frame(1'b0, pcm_cfg_t'(7'h00), 1'b0, 1'b0);
		apb(1'b0, 12'h004, 32'h0, rd, err);
		check(rd, 32'h0028_0105);
		bus_select_reset <= 1'b0;
	endtask

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		pclk             = 1'b0;
		presetn          = 1'b0;
		psel             = 1'b0;
		penable          = 1'b0;
		pwrite           = 1'b0;
		paddr            = 12'h000;
		pwdata           = 32'h0;
		diff_mode        = 1'b0;
		bus_select_reset = 1'b0;
		ref_low_swing    = 1'b0;
		pins             = '{1'b1, 1'b0, 1'b1, 1'b1, 3'h6};
		cycles           = 0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_style();
		t_frame(1'b0, '{1'b1, 1'b0, 1'b1, 1'b1, 3'h7}, 1'b0, 1'b0);
		t_frame(1'b1, '{1'b1, 1'b1, 1'b0, 1'b0, 3'h0}, 1'b0, 1'b1);
		t_frame(1'b0, '{1'b0, 1'b0, 1'b0, 1'b0, 3'h0}, 1'b1, 1'b0);
		t_frame(1'b1, '{1'b0, 1'b0, 1'b1, 1'b1, 3'h4}, 1'b1, 1'b1);
		t_regframe();
		complete_run();
	end
endmodule
